// file: led_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef LED_DEFS_SVH
`define LED_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CH3_CUR_HIGH 6'h07
`define IDX_CH3_CUR_LOW 6'h08
`define IDX_SWITCH_CTRL 6'h09
`define IDX_MEAS_MUX 6'h0a
`define IDX_DEAD_TIME 6'h0b
`define IDX_FAULT_STATUS 6'h0c
`define IDX_FAULT_MASK 6'h0d
`define IDX_DIRECT_MODE 6'h11

`define RST_ZERO 8'h00
`define RST_MASK 8'hdf

// Field positions
`define CUR_HIGH_MSB 1
`define SW_CH3_BIT 7
`define SW_CH1_BIT 5
`define TRIM_MSB 4
`define DIRECT_EN_BIT 0

// Channel select codes
`define SEL_NONE 2'h0
`define SEL_CH1 2'h1
`define SEL_CH2 2'h2
`define SEL_CH3 2'h3

// Timing
`define CLK_PERIOD_NS 40
`define SW_OFF_MIN_NS 333
`define SW_OFF_MAX_NS 444
`define SW_OFF_CYC ((`SW_OFF_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Two sync stages, detect and output stages absorb three cycles
`define SW_OFF_LOAD 4'((`SW_OFF_CYC) - 3)
`define DT_FIRST_NS 333
`define DT_STEP_NS 111

`endif

// file: led_pkg.sv
// Types shared by the register bank and its dead-time timer
package led_pkg;

  typedef enum logic [1:0] {
    SW_STEADY = 2'h0,
    SW_OFF_WAIT = 2'h1,
    SW_DEAD = 2'h3
  } sw_state_e;

  typedef struct packed {
    logic led_supply_overvoltage_flag;
    logic supply_power_good_fault_flag;
    logic projector_off_flag;
    logic mirror_regulator_fault_flag;
    logic undervoltage_lockout_flag;
    logic low_battery_flag;
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
  } fault_flags_s;

  typedef struct packed {
    logic meas_mux_enable;
    logic meas_calibration_disable;
    logic [1:0] meas_gain_select;
    logic [3:0] meas_input_select;
  } meas_ctrl_s;

  typedef struct packed {
    logic busy;
    logic [9:0] count;
    logic done;
  } timer_s;

  typedef struct packed {
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;
    logic [1:0] sel_prev;
    logic [7:0] flt_s1;
    logic [7:0] flt_s2;
    logic [1:0] cur_high;
    logic [7:0] cur_low;
    logic [7:0] sw_ctrl;
    meas_ctrl_s meas;
    logic [7:0] dead_code;
    logic [7:0] status;
    logic [7:0] mask;
    logic direct_en;
    sw_state_e fsm;
    logic [3:0] off_cnt;
    logic [2:0] target;
    logic [2:0] sw_on;
    logic timer_start;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } regs_s;

endpackage

// file: dead_timer.sv
// Break-before-make dead-time counter
`timescale 1ns/1ps
`include "led_defs.svh"
module dead_timer (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [7:0] code_in,
  output logic done_out
);

  led_pkg::timer_s st_r;
  led_pkg::timer_s st_nxt;

  // Code 0 gives no delay; else 333 ns plus 111 ns per step above code 1, rounded up
  function automatic logic [9:0] dead_cycles(input logic [7:0] code);
    int unsigned ns;
    ns = `DT_FIRST_NS + `DT_STEP_NS * (32'(code) - 32'd1);
    return 10'((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start_in) begin
      if (code_in == `RST_ZERO) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.busy = 1'b1;
        st_nxt.count = dead_cycles(code_in);
      end
    end else if (st_r.busy) begin
      st_nxt.count = st_r.count - 10'h001;
      if (st_r.count == 10'h001) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_out = st_r.done;

endmodule

// file: led_driver_control_registers.sv
// LED driver configuration, switch sequencing and fault interrupt registers
`timescale 1ns/1ps
`include "led_defs.svh"
module led_driver_control_registers (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] channel_select_inputs_in,
  input wire led_pkg::fault_flags_s fault_flags_in,
  output logic ch1_switch_on_out,
  output logic ch2_switch_on_out,
  output logic ch3_switch_on_out,
  output logic [9:0] ch3_current_code_out,
  output logic [4:0] lockout_threshold_trim_out,
  output led_pkg::meas_ctrl_s meas_ctrl_out,
  output logic irq_out
);

  led_pkg::regs_s st_r;
  led_pkg::regs_s st_nxt;
  logic timer_done;

  ////////////////////////////////////////////////////////////////////////////
  // Dead-time timer

  dead_timer u_dead_timer (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .start_in(st_r.timer_start),
    .code_in(st_r.dead_code),
    .done_out(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [2:0] sel_decode(input logic [1:0] sel);
    logic [2:0] oh;
    oh = 3'h0;
    if (sel == `SEL_CH1) begin
      oh = 3'h1;
    end else if (sel == `SEL_CH2) begin
      oh = 3'h2;
    end else if (sel == `SEL_CH3) begin
      oh = 3'h4;
    end
    return oh;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [5:0] idx;
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] rd;
    logic [7:0] status_set;
    logic sel_changed;
    idx = paddr[7:2];
    setup = psel && !penable && !st_r.pready;
    access = psel && penable && st_r.pready;
    mapped = 1'b1;
    rd = 32'h0000_0000;
    status_set = 8'h00;
    sel_changed = 1'b0;
    st_nxt = st_r;

    // Two-stage synchronisers
    st_nxt.sel_s1 = channel_select_inputs_in;
    st_nxt.sel_s2 = st_r.sel_s1;
    st_nxt.sel_prev = st_r.sel_s2;
    st_nxt.flt_s1 = fault_flags_in;
    st_nxt.flt_s2 = st_r.flt_s1;

    // Read decode during setup phase
    if (idx == `IDX_CH3_CUR_HIGH) begin
      rd = {30'h0000_0000, st_r.cur_high};
    end else if (idx == `IDX_CH3_CUR_LOW) begin
      rd = {24'h00_0000, st_r.cur_low};
    end else if (idx == `IDX_SWITCH_CTRL) begin
      rd = {24'h00_0000, st_r.sw_ctrl};
    end else if (idx == `IDX_MEAS_MUX) begin
      rd = {24'h00_0000, st_r.meas};
    end else if (idx == `IDX_DEAD_TIME) begin
      rd = {24'h00_0000, st_r.dead_code};
    end else if (idx == `IDX_FAULT_STATUS) begin
      rd = {24'h00_0000, st_r.status};
    end else if (idx == `IDX_FAULT_MASK) begin
      rd = {24'h00_0000, st_r.mask};
    end else if (idx == `IDX_DIRECT_MODE) begin
      rd = {31'h0000_0000, st_r.direct_en};
    end else begin
      mapped = 1'b0;
    end
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end

    st_nxt.pready = setup;
    if (setup) begin
      st_nxt.prdata = (mapped && !pwrite) ? rd : 32'h0000_0000;
      st_nxt.pslverr = !mapped;
    end else if (access) begin
      st_nxt.prdata = 32'h0000_0000;
      st_nxt.pslverr = 1'b0;
    end

    // Writes take effect at the completing edge
    if (access && pwrite && mapped) begin
      if (idx == `IDX_CH3_CUR_HIGH) begin
        st_nxt.cur_high = pwdata[`CUR_HIGH_MSB:0];
      end else if (idx == `IDX_CH3_CUR_LOW) begin
        st_nxt.cur_low = pwdata[7:0];
      end else if (idx == `IDX_SWITCH_CTRL) begin
        st_nxt.sw_ctrl = pwdata[7:0];
      end else if (idx == `IDX_MEAS_MUX) begin
        st_nxt.meas = pwdata[7:0];
      end else if (idx == `IDX_DEAD_TIME) begin
        st_nxt.dead_code = pwdata[7:0];
      end else if (idx == `IDX_FAULT_MASK) begin
        st_nxt.mask = pwdata[7:0];
      end else if (idx == `IDX_DIRECT_MODE) begin
        st_nxt.direct_en = pwdata[`DIRECT_EN_BIT];
      end
    end

    // Sticky fault bits: read clears, a present fault wins
    status_set = st_r.flt_s2;
    if (access && !pwrite && mapped && idx == `IDX_FAULT_STATUS) begin
      st_nxt.status = status_set;
    end else begin
      st_nxt.status = st_r.status | status_set;
    end
    st_nxt.irq = |(st_nxt.status & ~st_nxt.mask);

    // Switch sequencing
    sel_changed = st_r.sel_s2 != st_r.sel_prev;
    st_nxt.timer_start = 1'b0;
    if (st_r.direct_en) begin
      st_nxt.sw_on = st_r.sw_ctrl[`SW_CH3_BIT:`SW_CH1_BIT];
      st_nxt.fsm = led_pkg::SW_STEADY;
      st_nxt.target = sel_decode(st_r.sel_s2);
    end else if (sel_changed) begin
      st_nxt.target = sel_decode(st_r.sel_s2);
      st_nxt.off_cnt = `SW_OFF_LOAD;
      st_nxt.fsm = led_pkg::SW_OFF_WAIT;
    end else begin
      case (st_r.fsm)
        led_pkg::SW_STEADY: begin
          st_nxt.sw_on = st_r.target;
        end
        led_pkg::SW_OFF_WAIT: begin
          if (st_r.off_cnt == 4'h0) begin
            st_nxt.sw_on = 3'h0;
            st_nxt.timer_start = 1'b1;
            st_nxt.fsm = led_pkg::SW_DEAD;
          end else begin
            st_nxt.off_cnt = st_r.off_cnt - 4'h1;
          end
        end
        led_pkg::SW_DEAD: begin
          if (timer_done) begin
            st_nxt.sw_on = st_r.target;
            st_nxt.fsm = led_pkg::SW_STEADY;
          end
        end
        default: begin
          st_nxt.fsm = led_pkg::SW_STEADY;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
      st_r.mask <= `RST_MASK;
      st_r.fsm <= led_pkg::SW_STEADY;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign ch1_switch_on_out = st_r.sw_on[0];
  assign ch2_switch_on_out = st_r.sw_on[1];
  assign ch3_switch_on_out = st_r.sw_on[2];
  assign ch3_current_code_out = {st_r.cur_high, st_r.cur_low};
  assign lockout_threshold_trim_out = st_r.sw_ctrl[`TRIM_MSB:0];
  assign meas_ctrl_out = st_r.meas;
  assign irq_out = st_r.irq;

endmodule

// file: led_regs_monitor.sv
// Concurrent checks on the LED register bank ports
`timescale 1ns/1ps
module led_regs_monitor (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] channel_select_inputs_in,
  input wire logic ch1_switch_on_out,
  input wire logic ch2_switch_on_out,
  input wire logic ch3_switch_on_out,
  input wire logic [9:0] ch3_current_code_out,
  input wire led_pkg::meas_ctrl_s meas_ctrl_out
);
  logic direct_r;
  logic wr_ok;
  logic [2:0] sw;
  assign wr_ok = psel && penable && pready && pwrite;
  assign sw = {ch3_switch_on_out, ch2_switch_on_out, ch1_switch_on_out};
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  // Tracks direct mode from completed writes
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      direct_r <= 1'b0;
    end else if (wr_ok && paddr == 8'h44) begin
      direct_r <= pwdata[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  AST_LOW_BYTE: assert property (
    wr_ok && paddr == 8'h20 |=> ch3_current_code_out[7:0] == $past(pwdata[7:0])
  ) else $error("low byte not taken");
  AST_HIGH_BITS: assert property (
    wr_ok && paddr == 8'h1c |=> ch3_current_code_out[9:8] == $past(pwdata[1:0])
  ) else $error("high bits not taken");
  AST_CODE_HOLD: assert property (
    !(wr_ok && (paddr == 8'h1c || paddr == 8'h20))
      |=> $stable(ch3_current_code_out)
  ) else $error("current code moved");
  AST_MEAS: assert property (
    wr_ok && paddr == 8'h28 |=> meas_ctrl_out == $past(pwdata[7:0])
  ) else $error("mux control not taken");
  AST_STATUS_RO: assert property (
    pready && paddr == 8'h30 |-> !pslverr
  ) else $error("status access refused");
  AST_OFF_TIME: assert property (
    !direct_r && $changed(channel_select_inputs_in) |-> ##[9:11] sw == 3'h0
  ) else $error("switches not off in time");
  AST_ONE_ON: assert property (
    !direct_r |-> $onehot0(sw)
  ) else $error("two switches on");
  AST_DIRECT: assert property (
    wr_ok && paddr == 8'h24 && direct_r |=> ##1 sw == $past(pwdata[7:5], 2)
  ) else $error("direct switch mismatch");
endmodule
bind led_driver_control_registers led_regs_monitor u_mon (
  .clock_in, .resetn_in, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .channel_select_inputs_in, .ch1_switch_on_out,
  .ch2_switch_on_out, .ch3_switch_on_out, .ch3_current_code_out,
  .meas_ctrl_out
);

// file: apb_host.sv
// APB host model that reads and writes the register bank
`timescale 1ns/1ps
module apb_host (
  input wire logic clock_in,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Entered right after a rising edge; leaves one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    // Waits for the answer; only the bench watchdog ends a hang
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clock_in);
  endtask
endmodule

// file: tb_led_regs.sv
// Self-checking bench of the LED register bank
`timescale 1ns/1ps
module testbench;
  logic clock_in, resetn_in, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] sel;
  led_pkg::fault_flags_s flt;
  logic sw1, sw2, sw3, irq;
  logic [9:0] code;
  logic [4:0] trim;
  led_pkg::meas_ctrl_s meas;
  int miscompares, checked;
  led_driver_control_registers u_led_driver_control_registers (
    .clock_in, .resetn_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .channel_select_inputs_in(sel),
    .fault_flags_in(flt), .ch1_switch_on_out(sw1), .ch2_switch_on_out(sw2),
    .ch3_switch_on_out(sw3), .ch3_current_code_out(code),
    .lockout_threshold_trim_out(trim), .meas_ctrl_out(meas), .irq_out(irq)
  );
  apb_host u_apb_host (.clock_in, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_apb_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    u_apb_host.xfer(1'b0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask
  //////////////////////////////////////////////////////////////////////////
  task t_reset_values;
    rd(8'h20, 32'h0, 1'b0);
    rd(8'h28, 32'h0, 1'b0);
    rd(8'h2c, 32'h0, 1'b0);
    rd(8'h30, 32'h0, 1'b0);
    rd(8'h34, 32'hdf, 1'b0);
  endtask
  task t_codes;
    wr(8'h1c, 32'h3);
    wr(8'h20, 32'hff);
    check(32'(code), 32'h3ff);
    wr(8'h1c, 32'h1);
    wr(8'h20, 32'h0);
    check(32'(code), 32'h100);
    rd(8'h20, 32'h0, 1'b0);
    wr(8'h28, 32'h96);
    check(32'(meas), 32'h96);
    rd(8'h28, 32'h96, 1'b0);
    wr(8'h2c, 32'hff);
    rd(8'h2c, 32'hff, 1'b0);
    wr(8'h30, 32'hff);
    rd(8'h30, 32'h0, 1'b0);
    rd(8'hfc, 32'h0, 1'b1);
    rd(8'h21, 32'h0, 1'b1);
  endtask
  task t_irq;
    flt <= 8'h01;
    repeat (5) @(posedge clock_in);
    check({31'h0, irq}, 32'h0);
    wr(8'h34, 32'hfe);
    @(posedge clock_in);
    check({31'h0, irq}, 32'h1);
    flt <= 8'h00;
    repeat (4) @(posedge clock_in);
    rd(8'h30, 32'h01, 1'b0);
    @(posedge clock_in);
    check({31'h0, irq}, 32'h0);
    wr(8'h34, 32'hdf);
    // Source left unmasked by the reset mask
    flt <= 8'h20;
    repeat (5) @(posedge clock_in);
    check({31'h0, irq}, 32'h1);
    // A fault still present sets its bit again at the clearing read
    rd(8'h30, 32'h20, 1'b0);
    rd(8'h30, 32'h20, 1'b0);
    flt <= 8'h00;
    repeat (4) @(posedge clock_in);
    rd(8'h30, 32'h20, 1'b0);
    rd(8'h30, 32'h00, 1'b0);
    @(posedge clock_in);
    check({31'h0, irq}, 32'h0);
  endtask
  task t_switch;
    int n;
    wr(8'h2c, 32'h01);
    sel <= 2'h2;
    n = 0;
    while (sw2 !== 1'b1 && n < 80) begin
      @(posedge clock_in);
      n++;
    end
    check({29'h0, sw3, sw2, sw1}, 32'h2);
    sel <= 2'h3;
    n = 0;
    while (sw2 === 1'b1 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(n >= 10 && n <= 12), 32'h1);
    n = 0;
    while (sw3 !== 1'b1 && n < 40) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(n >= 9 && n <= 12), 32'h1);
    // Code zero: next switch follows the off step two cycles later
    wr(8'h2c, 32'h00);
    sel <= 2'h1;
    n = 0;
    while (sw3 === 1'b1 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(n >= 10 && n <= 12), 32'h1);
    n = 0;
    while (sw1 !== 1'b1 && n < 20) begin
      @(posedge clock_in);
      n++;
    end
    check(32'(n >= 1 && n <= 2), 32'h1);
    check({29'h0, sw3, sw2, sw1}, 32'h1);
  endtask
  task t_direct;
    wr(8'h44, 32'h1);
    wr(8'h24, 32'ha3);
    @(posedge clock_in);
    check({29'h0, sw3, sw2, sw1}, 32'h5);
    check(32'(trim), 32'h03);
    wr(8'h24, 32'h0);
    wr(8'h44, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    resetn_in = 1'b0;
    sel = 2'h0;
    flt = 8'h00;
    miscompares = 0;
    checked = 0;
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    @(posedge clock_in);
    t_reset_values;
    t_codes;
    t_irq;
    t_switch;
    t_direct;
    print_verdict;
  end
  initial begin
    #200000;
    miscompares++;
    print_verdict;
  end
endmodule
